// ---- temp_sensor_twowire_slave_tb.sv ----
// Bench for the host master and sensor slave pair
module temp_sensor_twowire_slave_tb
  import tsws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] address_select_pin = 2'h0;
  logic [12:0] temp_code_in = 13'h0000;
  logic temp_valid_in = 1'b0;
  logic alert_n_out;
  logic [15:0] config_out;
  logic [1:0] pointer_select_bits_out;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] rd;
  logic [12:0] codes [2] = '{13'h1FFC, 13'h0960};
  logic [15:0] words [2] = '{16'hFFE1, 16'h4B01};
  int mismatches = 0;
  int n_tests = 0;
  tsws_link_if link ();
  tsws_slave i_tsws_slave (.*);
  tsws_master #(.HALF_CYC(4)) i_tsws_master (.*);
  tsws_link_assertions i_tsws_link_assertions (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
    .scl(link.scl), .sda(link.sda));
  // Clock
  initial forever #5 ref_clk_in = ~ref_clk_in;
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register bus write and read
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // One link transaction, then wait until idle
  task automatic xfer(input logic [2:0] c, input logic [6:0] a, input logic [2:0] nb, input logic [23:0] w);
    axi_wr(TSWS_OFF_WDATA, {8'h00, w});
    axi_wr(TSWS_OFF_CMD, {13'h0000, nb, 1'b0, a, 5'h00, c});
    do
      axi_rd(TSWS_OFF_STATUS);
    while (rd[0] !== 1'b0);
  endtask
  task automatic set_temp(input logic [12:0] t);
    temp_code_in <= t;
    temp_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    temp_valid_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #600000;
    mismatches++;
    give_verdict();
  end
  // Test sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    chk("pointer", pointer_select_bits_out, TSWS_PTR_RESET);
    set_temp(13'h1E70);
    xfer(TSWS_CMD_READ, TSWS_ADDR_BASE, 3'h3, 24'h000000);
    axi_rd(TSWS_OFF_RDATA);
    chk("temp normal", rd[15:0], 16'hE700);
    $display("done: normal read");
    for (int k = 0; k < 4; k++)
    begin
      address_select_pin <= k[1:0];
      xfer(TSWS_CMD_WRITE, TSWS_ADDR_BASE + 7'(k), 3'h2, 24'h000000);
      chk("ack own", rd[1], 1'b0);
      xfer(TSWS_CMD_WRITE, TSWS_ADDR_BASE + 7'(k + 1), 3'h2, 24'h000000);
      chk("nack other", rd[1], 1'b1);
    end
    $display("done: address select");
    set_temp(13'h0320);
    xfer(TSWS_CMD_WRITE, TSWS_ADDR_BASE + 7'h3, 3'h4, {6'h00, TSWS_PTR_CONF, 16'h62A0});
    set_temp(13'h0640);
    axi_rd(TSWS_OFF_STATUS);
    chk("alert set", alert_n_out, 1'b0);
    xfer(TSWS_CMD_ALERT, TSWS_ALERT_CMD[7:1], 3'h2, 24'h000000);
    axi_rd(TSWS_OFF_RDATA);
    chk("alert addr", rd[7:0], {TSWS_ADDR_BASE + 7'h3, 1'b1});
    chk("alert clear", alert_n_out, 1'b1);
    $display("done: alert");
    xfer(TSWS_CMD_WRITE, TSWS_ADDR_BASE + 7'h3, 3'h4, {6'h00, TSWS_PTR_CONF, 16'h62B0});
    chk("config", config_out, 32'h000062B0);
    xfer(TSWS_CMD_READ, TSWS_ADDR_BASE + 7'h3, 3'h3, 24'h000000);
    axi_rd(TSWS_OFF_RDATA);
    chk("config read", rd[15:0], 16'h62B0);
    xfer(TSWS_CMD_WRITE, TSWS_ADDR_BASE + 7'h3, 3'h2, {6'h00, TSWS_PTR_TEMP, 16'h0000});
    chk("pointer", pointer_select_bits_out, TSWS_PTR_TEMP);
    $display("done: config and pointer");
    for (int k = 0; k < 2; k++)
    begin
      set_temp(codes[k]);
      xfer(TSWS_CMD_READ, TSWS_ADDR_BASE + 7'h3, 3'h3, 24'h000000);
      axi_rd(TSWS_OFF_RDATA);
      chk("temp extended", rd[15:0], words[k]);
    end
    $display("done: extended format");
    xfer(TSWS_CMD_WRITE, TSWS_GCALL_ADDR, 3'h2, {TSWS_GCALL_RESET, 16'h0000});
    chk("gcall ack", rd[1], 1'b0);
    chk("config reset", config_out, TSWS_CONF_RESET);
    $display("done: general call");
    give_verdict();
  end
endmodule

// ---- tsws_link_assertions.sv ----
// Checker of the two-wire link between host and sensor
module tsws_link_assertions
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic [3:0] rise_q;
  logic [3:0] rise_d;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Clock rises while the slave holds data low
  always_comb
  begin
    rise_d = (sda_s_oe && reset_n_in) ? rise_q + {3'h0, scl && !scl_q} : 4'h0;
  end
  always_ff @(posedge ref_clk_in)
  begin
    scl_q <= scl;
    rise_q <= rise_d;
  end
  // Link relations
  scl_host_only_a: assert property (!scl |-> scl_oe && !scl_o)
    else $error("clock low without host");
  sda_pull_low_a: assert property (sda_s_oe |-> !sda_s_o && !sda)
    else $error("slave drive not low");
  sda_turn_low_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data moved with clock high");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high too short");
  scl_low_min_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low too short");
  start_by_host_a: assert property (scl && $fell(sda) |-> !sda_s_oe)
    else $error("slave made a start");
  stop_released_a: assert property (scl && $rose(sda) |-> !$past(sda_s_oe))
    else $error("slave held data at stop");
  drive_bound_a: assert property (rise_q <= 4'h9)
    else $error("slave held data too long");
endmodule

// ---- tsws_link_if.sv ----
// Open-drain two-wire link joining the sensor slave and the host master
interface tsws_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

// ---- tsws_master.sv ----
// Two-wire host master with AXI4-Lite command registers
module tsws_master
  import tsws_pkg::*;
#(
  parameter int HALF_CYC = TSWS_SCL_HALF_CYC
)
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  tsws_link_if.master link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (HALF_CYC < 4) $error("HALF_CYC too small");
  typedef enum {TSWS_M_IDLE, TSWS_M_START, TSWS_M_BIT, TSWS_M_STOP} tsws_mstate_t;
  tsws_mstate_t st_q, st_d;
  logic [15:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] nbytes_q, nbytes_d, bidx_q, bidx_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [2:0] cmd_q, cmd_d;
  logic [7:0] addr_q, addr_d;
  logic busy_q, busy_d, nack_q, nack_d, go_q, go_d;
  logic scl_q, scl_d, sda_q, sda_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] wbuf_q, wbuf_d;
  logic tick;
  assign tick = div_q == 16'(HALF_CYC - 1);

  // Byte to send for a given byte index of the frame
  function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic rd);
    case (i)
      3'h0: tx_byte = (cmd_q == TSWS_CMD_ALERT) ? TSWS_ALERT_CMD : {addr_q[6:0], rd};
      3'h1: tx_byte = wdata_q[23:16];
      3'h2: tx_byte = wdata_q[15:8];
      default: tx_byte = wdata_q[7:0];
    endcase
  endfunction

  // Bus slave and bit engine
  always_comb
  begin
    st_d = st_q;
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
    ph_d = ph_q;
    sh_d = sh_q;
    bit_d = bit_q;
    nbytes_d = nbytes_q;
    bidx_d = bidx_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    busy_d = busy_q;
    nack_d = nack_q;
    go_d = 1'b0;
    scl_d = scl_q;
    sda_d = sda_q;
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    rv_d = rv_q;
    awa_d = awa_q;
    rd_d = rd_q;
    wbuf_d = wbuf_q;
    if (s_axi_awvalid && !aw_q && !bv_q)
    begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q)
    begin
      w_d = 1'b1;
      wbuf_d = s_axi_wdata;
    end
    if (aw_q && w_q)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      if (awa_q == TSWS_OFF_WDATA)
      begin
        wdata_d = wbuf_q;
      end
      else if (awa_q == TSWS_OFF_CMD && !busy_q)
      begin
        cmd_d = wbuf_q[2:0];
        addr_d = wbuf_q[15:8];
        nbytes_d = wbuf_q[18:16];
        go_d = 1'b1;
        busy_d = 1'b1;
      end
    end
    if (bv_q && s_axi_bready)
    begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q)
    begin
      rv_d = 1'b1;
      case (s_axi_araddr)
        TSWS_OFF_STATUS: rd_d = {30'h00000000, nack_q, busy_q};
        TSWS_OFF_RDATA: rd_d = rdata_q;
        TSWS_OFF_WDATA: rd_d = wdata_q;
        default: rd_d = 32'h00000000;
      endcase
    end
    if (rv_q && s_axi_rready)
    begin
      rv_d = 1'b0;
    end
    // Frame: start, bytes with acknowledge, stop; master owns the clock
    case (st_q)
      TSWS_M_IDLE:
      begin
        if (go_q)
        begin
          st_d = TSWS_M_START;
          ph_d = 2'h0;
          bidx_d = 3'h0;
          nack_d = 1'b0;
          rdata_d = 32'h00000000;
        end
      end
      TSWS_M_START:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0)
          begin
            sda_d = 1'b1;
            scl_d = 1'b1;
          end
          else if (ph_q == 2'h1)
          begin
            sda_d = 1'b0;
          end
          else
          begin
            scl_d = 1'b0;
            sh_d = {tx_byte(bidx_q, cmd_q == TSWS_CMD_READ), 1'b1};
            bit_d = 4'h0;
            ph_d = 2'h0;
            st_d = TSWS_M_BIT;
          end
        end
      end
      TSWS_M_BIT:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0)
          begin
            sda_d = sh_q[8];
          end
          else if (ph_q == 2'h1)
          begin
            scl_d = 1'b1;
          end
          else if (ph_q == 2'h2)
          begin
            sh_d = {sh_q[7:0], link.sda};
          end
          else
          begin
            scl_d = 1'b0;
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h8)
            begin
              bit_d = 4'h0;
              bidx_d = bidx_q + 3'h1;
              if (bidx_q != 3'h0 && (cmd_q == TSWS_CMD_READ || cmd_q == TSWS_CMD_ALERT))
              begin
                rdata_d = {rdata_q[23:0], sh_q[8:1]};
              end
              else if (sh_q[0])
              begin
                nack_d = 1'b1;
              end
              if ((bidx_q == 3'h0 && sh_q[0]) || bidx_q + 3'h1 >= nbytes_q)
              begin
                st_d = TSWS_M_STOP;
              end
              else if (cmd_q == TSWS_CMD_READ || cmd_q == TSWS_CMD_ALERT)
              begin
                // Acknowledge all but the last read byte
                sh_d = {8'hFF, bidx_q + 3'h2 >= nbytes_q};
              end
              else
              begin
                sh_d = {tx_byte(bidx_q + 3'h1, 1'b0), 1'b1};
              end
            end
          end
        end
      end
      TSWS_M_STOP:
      begin
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0)
          begin
            sda_d = 1'b0;
          end
          else if (ph_q == 2'h1)
          begin
            scl_d = 1'b1;
          end
          else if (ph_q == 2'h2)
          begin
            sda_d = 1'b1;
            st_d = TSWS_M_IDLE;
            busy_d = 1'b0;
          end
        end
      end
      default: st_d = TSWS_M_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      st_q <= TSWS_M_IDLE;
      div_q <= 16'h0000;
      ph_q <= 2'h0;
      sh_q <= 9'h1FF;
      bit_q <= 4'h0;
      nbytes_q <= 3'h0;
      bidx_q <= 3'h0;
      wdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      cmd_q <= 3'h0;
      addr_q <= 8'h00;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      go_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      rd_q <= 32'h00000000;
      wbuf_q <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      nbytes_q <= nbytes_d;
      bidx_q <= bidx_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      busy_q <= busy_d;
      nack_q <= nack_d;
      go_q <= go_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      rd_q <= rd_d;
      wbuf_q <= wbuf_d;
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda_q;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = 2'h0;
endmodule

// ---- tsws_pkg.sv ----
// Shared constants for the two-wire temperature sensor link
package tsws_pkg;
  localparam logic [6:0] TSWS_ADDR_BASE = 7'h48;
  localparam logic [6:0] TSWS_GCALL_ADDR = 7'h00;
  localparam logic [7:0] TSWS_GCALL_RESET = 8'h06;
  localparam logic [7:0] TSWS_ALERT_CMD = 8'h19;
  localparam logic [1:0] TSWS_PTR_RESET = 2'h0;
  localparam logic [1:0] TSWS_PTR_TEMP = 2'h0;
  localparam logic [1:0] TSWS_PTR_CONF = 2'h1;
  localparam logic [1:0] TSWS_PTR_TLOW = 2'h2;
  localparam logic [1:0] TSWS_PTR_THIGH = 2'h3;
  localparam int TSWS_CONF_EM_BIT = 4;
  localparam int TSWS_CONF_TM_BIT = 9;
  localparam logic [15:0] TSWS_CONF_RESET = 16'h60A0;
  localparam logic [15:0] TSWS_TLOW_RESET = 16'h4B00;
  localparam logic [15:0] TSWS_THIGH_RESET = 16'h5000;
  localparam int TSWS_SCL_HALF_CYC = 8;
  localparam logic [1:0] TSWS_SEL_GND = 2'h0;
  localparam logic [1:0] TSWS_SEL_VDD = 2'h1;
  localparam logic [1:0] TSWS_SEL_SDA = 2'h2;
  localparam logic [1:0] TSWS_SEL_SCL = 2'h3;
  localparam logic [2:0] TSWS_CMD_WRITE = 3'h0;
  localparam logic [2:0] TSWS_CMD_READ = 3'h1;
  localparam logic [2:0] TSWS_CMD_ALERT = 3'h2;
  localparam logic [2:0] TSWS_CMD_GCALL = 3'h3;
  localparam logic [2:0] TSWS_CMD_PTR = 3'h4;
  localparam logic [7:0] TSWS_OFF_CMD = 8'h00;
  localparam logic [7:0] TSWS_OFF_WDATA = 8'h04;
  localparam logic [7:0] TSWS_OFF_STATUS = 8'h08;
  localparam logic [7:0] TSWS_OFF_RDATA = 8'h0C;
endpackage

// ---- tsws_slave.sv ----
// Two-wire temperature sensor slave: address, pointer, registers, alert
// Functional notes
// - Slave only, never drives clock line
// - Fast and high-speed clock ranges supported
// - Bytes go most significant bit first
// - Master keeps data stable while clock high
// - Address plus direction sampled on rising edges
// - Matching address acknowledged on ninth pulse
// - Select pin gives four consecutive addresses
// - First write byte loads the pointer
// - Reads use last written pointer value
// - Master writes pointer then restarts to read
// - Register words go high byte first
// - Receiver acknowledges and stores until stop
// - Transmitter sends high then low byte
// - Normal format 12-bit left-justified twos complement
// - Negative values are twos complement
// - Extended format uses 13-bit code
// - Alert command answered with own address
// - Returned address low bit shows limit side
// - Lowest address wins, winner clears alert
// - Interrupt alert sets on limits, clears on read (code clears only on reads with the pointer at temperature)
// - Pointer low bits select, reset to zero
// - Temperature low bit flags extended format
// - General call reset command restores registers
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
module tsws_slave
  import tsws_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  tsws_link_if.slave link,
  input wire logic [1:0] address_select_pin,
  input wire logic [12:0] temp_code_in,
  input wire logic temp_valid_in,
  output logic alert_n_out,
  output logic [15:0] config_out,
  output logic [1:0] pointer_select_bits_out
);
  typedef enum {TSWS_S_IDLE, TSWS_S_ADDR, TSWS_S_AACK, TSWS_S_RX, TSWS_S_RACK,
                TSWS_S_TX, TSWS_S_TACK, TSWS_S_SKIP} tsws_state_t;
  typedef enum {TSWS_K_NONE, TSWS_K_DEV, TSWS_K_GCALL, TSWS_K_ALERT} tsws_kind_t;

  logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
  logic scl_prev_q, scl_prev_d, sda_prev_q, sda_prev_d;
  tsws_state_t state_q, state_d;
  tsws_kind_t kind_q, kind_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic rw_q, rw_d;
  logic sda_oe_q, sda_oe_d;
  logic [1:0] ptr_q, ptr_d;
  logic [15:0] conf_q, conf_d, tlow_q, tlow_d, thigh_q, thigh_d, temp_q, temp_d;
  logic [7:0] hold_q, hold_d;
  logic alert_q, alert_d, above_q, above_d, over_q, over_d, under_q, under_d;
  logic [1:0] sel_q, sel_d, sel_meta_q, sel_meta_d;
  logic [15:0] cur_word;
  logic [6:0] own_addr;
  logic scl_rise, scl_fall, start_ev, stop_ev, em, tm;
  logic signed [12:0] t13, lo13, hi13;

  // Synchronisers: second stage only is read
  always_comb
  begin
    scl_sync_d = {scl_sync_q[0], link.scl};
    sda_sync_d = {sda_sync_q[0], link.sda};
    scl_prev_d = scl_sync_q[1];
    sda_prev_d = sda_sync_q[1];
    sel_meta_d = address_select_pin;
    sel_d = sel_meta_q;
  end

  assign scl_rise = scl_sync_q[1] && !scl_prev_q;
  assign scl_fall = !scl_sync_q[1] && scl_prev_q;
  assign start_ev = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
  assign stop_ev = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
  assign own_addr = TSWS_ADDR_BASE | {5'h00, sel_q};
  assign em = conf_q[TSWS_CONF_EM_BIT];
  assign tm = conf_q[TSWS_CONF_TM_BIT];

  // Register word to transmit for a pointer value
  function automatic logic [15:0] reg_word(input logic [1:0] p);
    case (p)
      TSWS_PTR_TEMP: reg_word = temp_q;
      TSWS_PTR_CONF: reg_word = conf_q;
      TSWS_PTR_TLOW: reg_word = tlow_q;
      default: reg_word = thigh_q;
    endcase
  endfunction

  // Align a register word to 13-bit signed temperature
  function automatic logic signed [12:0] to13(input logic [15:0] w, input logic ext);
    to13 = ext ? w[15:3] : {w[15], w[15:4]};
  endfunction

  assign t13 = to13(temp_q, em);
  assign lo13 = to13(tlow_q, em);
  assign hi13 = to13(thigh_q, em);
  assign cur_word = reg_word(ptr_q);

  // Protocol engine and register file
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    shift_d = shift_q;
    bit_d = bit_q;
    byte_d = byte_q;
    rw_d = rw_q;
    sda_oe_d = sda_oe_q;
    ptr_d = ptr_q;
    conf_d = conf_q;
    tlow_d = tlow_q;
    thigh_d = thigh_q;
    temp_d = temp_q;
    hold_d = hold_q;
    alert_d = alert_q;
    above_d = above_q;
    over_d = t13 > hi13;
    under_d = t13 < lo13;
    // Temperature capture, format flag in bit zero
    if (temp_valid_in)
    begin
      temp_d = em ? {temp_code_in, 3'h1} : {temp_code_in[11:0], 4'h0};
    end
    if (stop_ev)
    begin
      state_d = TSWS_S_IDLE;
      sda_oe_d = 1'b0;
    end
    else if (start_ev)
    begin
      state_d = TSWS_S_ADDR;
      bit_d = 4'h0;
      sda_oe_d = 1'b0;
    end
    else
    begin
      case (state_q)
        TSWS_S_ADDR, TSWS_S_RX:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_sync_q[1]};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == 4'h8)
          begin
            bit_d = 4'h0;
            if (state_q == TSWS_S_ADDR)
            begin
              rw_d = shift_q[0];
              byte_d = 2'h0;
              if (shift_q[7:1] == own_addr)
              begin
                kind_d = TSWS_K_DEV;
                sda_oe_d = 1'b1;
                state_d = TSWS_S_AACK;
              end
              else if (shift_q == {TSWS_GCALL_ADDR, 1'b0})
              begin
                kind_d = TSWS_K_GCALL;
                sda_oe_d = 1'b1;
                state_d = TSWS_S_AACK;
              end
              else if (shift_q == TSWS_ALERT_CMD && alert_q)
              begin
                kind_d = TSWS_K_ALERT;
                sda_oe_d = 1'b1;
                state_d = TSWS_S_AACK;
              end
              else
              begin
                state_d = TSWS_S_SKIP;
              end
            end
            else
            begin
              sda_oe_d = 1'b1;
              state_d = TSWS_S_RACK;
              if (kind_q == TSWS_K_GCALL)
              begin
                if (shift_q == TSWS_GCALL_RESET)
                begin
                  ptr_d = TSWS_PTR_RESET;
                  conf_d = TSWS_CONF_RESET;
                  tlow_d = TSWS_TLOW_RESET;
                  thigh_d = TSWS_THIGH_RESET;
                  temp_d = 16'h0000;
                  alert_d = 1'b0;
                end
              end
              else if (byte_q == 2'h0)
              begin
                ptr_d = shift_q[1:0];
                byte_d = 2'h1;
              end
              else if (byte_q == 2'h1)
              begin
                hold_d = shift_q;
                byte_d = 2'h2;
              end
              else
              begin
                byte_d = 2'h1;
                case (ptr_q)
                  TSWS_PTR_CONF: conf_d = {hold_q, shift_q};
                  TSWS_PTR_TLOW: tlow_d = {hold_q, shift_q};
                  TSWS_PTR_THIGH: thigh_d = {hold_q, shift_q};
                  default: ;
                endcase
              end
            end
          end
        end
        TSWS_S_AACK, TSWS_S_RACK:
        begin
          if (scl_fall)
          begin
            sda_oe_d = 1'b0;
            if (state_q == TSWS_S_AACK && kind_q == TSWS_K_ALERT)
            begin
              shift_d = {own_addr, above_q};
              state_d = TSWS_S_TX;
              sda_oe_d = !own_addr[6];
            end
            else if (state_q == TSWS_S_AACK && rw_q)
            begin
              shift_d = cur_word[15:8];
              state_d = TSWS_S_TX;
              sda_oe_d = !cur_word[15];
              if (ptr_q == TSWS_PTR_TEMP && tm)
              begin
                alert_d = 1'b0;
              end
            end
            else
            begin
              state_d = TSWS_S_RX;
            end
          end
        end
        TSWS_S_TX:
        begin
          if (scl_rise)
          begin
            bit_d = bit_q + 4'h1;
            // Lost arbitration: line low while we released it
            if (sda_oe_q == 1'b0 && !sda_sync_q[1] && kind_q == TSWS_K_ALERT)
            begin
              state_d = TSWS_S_SKIP;
            end
          end
          else if (scl_fall)
          begin
            shift_d = {shift_q[6:0], 1'b0};
            if (bit_q == 4'h8)
            begin
              sda_oe_d = 1'b0;
              state_d = TSWS_S_TACK;
              bit_d = 4'h0;
              if (kind_q == TSWS_K_ALERT)
              begin
                alert_d = 1'b0;
              end
            end
            else
            begin
              sda_oe_d = !shift_q[6];
            end
          end
        end
        TSWS_S_TACK:
        begin
          if (scl_rise)
          begin
            if (sda_sync_q[1] || kind_q == TSWS_K_ALERT)
            begin
              state_d = TSWS_S_SKIP;
            end
            else
            begin
              shift_d = cur_word[7:0];
              byte_d = byte_q + 2'h1;
            end
          end
          else if (scl_fall)
          begin
            state_d = TSWS_S_TX;
            sda_oe_d = !shift_q[7];
          end
        end
        default: ;
      endcase
    end
    // Alert fires on a limit crossing, so a read clear is not undone next cycle; set beats clear
    if (!tm)
    begin
      alert_d = 1'b0;
    end
    else if (over_d && !over_q)
    begin
      alert_d = 1'b1;
      above_d = 1'b1;
    end
    else if (under_d && !under_q)
    begin
      alert_d = 1'b1;
      above_d = 1'b0;
    end
  end

  // State registers; link SDA only ever pulled low, clock never driven
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      state_q <= TSWS_S_IDLE;
      kind_q <= TSWS_K_NONE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ptr_q <= TSWS_PTR_RESET;
      conf_q <= TSWS_CONF_RESET;
      tlow_q <= TSWS_TLOW_RESET;
      thigh_q <= TSWS_THIGH_RESET;
      temp_q <= 16'h0000;
      hold_q <= 8'h00;
      alert_q <= 1'b0;
      above_q <= 1'b0;
      over_q <= 1'b0;
      under_q <= 1'b0;
      sel_meta_q <= 2'h0;
      sel_q <= 2'h0;
    end
    else
    begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      state_q <= state_d;
      kind_q <= kind_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      sda_oe_q <= sda_oe_d;
      ptr_q <= ptr_d;
      conf_q <= conf_d;
      tlow_q <= tlow_d;
      thigh_q <= thigh_d;
      temp_q <= temp_d;
      hold_q <= hold_d;
      alert_q <= alert_d;
      above_q <= above_d;
      over_q <= over_d;
      under_q <= under_d;
      sel_meta_q <= sel_meta_d;
      sel_q <= sel_d;
    end
  end

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = sda_oe_q;
  assign alert_n_out = !alert_q;
  assign config_out = conf_q;
  assign pointer_select_bits_out = ptr_q;
endmodule
